// file: bench/iplr_src_model.sv
// far-side model: peripheral sources raising request levels
`timescale 1ns/1ps
module iplr_src_model import iplr_pkg::*; (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // levels the bench asks for
  input wire logic [SRC_COUNT-1:0] pattern,
  // request lines into the block
  output logic [SRC_COUNT-1:0] src_irq
);
  // launched just after the edge, like a registered peripheral flag
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      src_irq <= '0;
    end else begin
      src_irq <= pattern;
    end
  end
endmodule

// file: bench/iplr_top_tb.sv
// self-checking bench for the priority level register block
`timescale 1ns/1ps
module iplr_top_tb;
  import iplr_pkg::*;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [SRC_COUNT-1:0] pattern, src_irq, req_valid;
  logic [2*SRC_COUNT-1:0] req_level;
  logic [1:0] bq[$];
  logic [33:0] rq[$];
  logic [56:0] qq[$];
  logic [15:0] sh[4];
  int failures, samples_checked;
  // writable bits per word; the rest must read zero
  localparam logic [15:0] MASK[4] = '{16'h3c00, 16'h003f, 16'hffcf, 16'hfffc};
  // word and low bit of each source field, by source number
  localparam int WRD[19] = '{0,0,1,1,1,2,2,2,2,2,2,2,3,3,3,3,3,3,3};
  localparam int LSB[19] = '{12,10,4,2,0,14,12,10,8,6,2,0,14,12,10,8,6,4,2};

  iplr_top #(.ADDR_W(8)) u_iplr_top (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .src_irq(src_irq), .req_valid(req_valid),
    .req_level(req_level)
  );
  iplr_src_model u_iplr_src_model (
    .aclk(aclk), .aresetn(aresetn), .pattern(pattern), .src_irq(src_irq)
  );

  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  // ----------------------------------------------------------------
  // checking
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [63:0] exp,
                       input logic [63:0] got);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  function automatic logic [56:0] exp_req(input logic [SRC_COUNT-1:0] s);
    logic [SRC_COUNT-1:0] v;
    logic [2*SRC_COUNT-1:0] l;
    logic [1:0] f;
    v = '0;
    l = '0;
    for (int i = 0; i < SRC_COUNT; i++) begin
      f = sh[WRD[i]][LSB[i] +: 2];
      if (s[i] && f != 2'h0) begin
        v[i] = 1'b1;
        l[2*i +: 2] = (i < 5) ? f : f - 2'h1;
      end
    end
    return {v, l};
  endfunction

  // monitors take the oldest note when a result shows up
  always @(posedge aclk) begin
    if (bvalid && bready) begin
      check("bresp", bq.size() ? bq.pop_front() : 'x, bresp);
    end
    if (rvalid && rready) begin
      check("read", rq.size() ? rq.pop_front() : 'x,
            {rresp, rdata});
    end
  end
  always @(negedge aclk) begin
    if (qq.size() != 0) begin
      check("req", qq.pop_front(), {req_valid, req_level});
    end
  end

  // ----------------------------------------------------------------
  // bus master
  // ----------------------------------------------------------------
  task automatic axi_write(input logic [7:0] a, input logic [31:0] v,
                           input logic [3:0] s);
    int n;
    int lag;
    // a late bready makes the slave hold its response
    lag = int'($urandom % 4);
    bq.push_back(a[7:2] < 6'd4 ? RESP_OKAY : RESP_DECERR);
    awaddr <= a;
    wdata <= v;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= (lag == 0);
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready) break;
      if (n + 1 >= lag) bready <= 1'b1;
    end
    if (n == 50) begin
      failures++;
      wrap_up();
    end
    if (a[7:2] < 6'd4) for (int b = 0; b < 2; b++)
      if (s[b]) sh[a[3:2]][8*b +: 8] = v[8*b +: 8] & MASK[a[3:2]][8*b +: 8];
  endtask

  task automatic axi_read(input logic [7:0] a);
    int n;
    int lag;
    lag = int'($urandom % 4);
    rq.push_back(a[7:2] < 6'd4 ? {RESP_OKAY, 16'h0, sh[a[3:2]]}
                               : {RESP_DECERR, 32'h0});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= (lag == 0);
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) break;
      if (n + 1 >= lag) rready <= 1'b1;
    end
    if (n == 50) begin
      failures++;
      wrap_up();
    end
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'hbbf9));
    {aresetn, awvalid, wvalid, arvalid, awaddr, araddr, wdata} = '0;
    {bready, rready, wstrb} = '1;
    pattern = '0;
    sh = '{default: 16'h0};
    failures = 0;
    samples_checked = 0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    for (int r = 0; r < 4; r++) axi_read(8'(4*r));
    // unmapped place: refused, no side effect
    axi_write(8'h10, 32'hffffffff, 4'hf);
    axi_read(8'h10);
    for (int it = 0; it < 24; it++) begin
      for (int r = 0; r < 4; r++) begin
        d = it < 4 ? {16{it[1:0]}} : $urandom;
        axi_write(8'(4*r), d, it % 3 == 2 ? 4'($urandom) : 4'hf);
      end
      for (int r = 0; r < 4; r++) axi_read(8'(4*r));
      pattern <= it < 4 ? '1 : SRC_COUNT'($urandom);
      repeat (2) @(posedge aclk);
      qq.push_back(exp_req(pattern));
      @(posedge aclk);
    end
    repeat (2) @(posedge aclk);
    wrap_up();
  end
endmodule

// file: design/iplr_level_decode.sv
// decoder of one 2-bit priority field into enable and level
`timescale 1ns/1ps
module iplr_level_decode import iplr_pkg::*; #(
  parameter logic [1:0] LEVEL_OFFSET = LEVEL_OFFSET_SYSTEM
) (
  // field
  input wire logic [1:0] field,
  // decoded
  output logic enabled,
  output logic [1:0] level
);

  always_comb begin
    enabled = (field != FIELD_DISABLED);
    // wraps on purpose: 01 plus 11 gives level 0
    level = 2'(field + LEVEL_OFFSET);
  end

endmodule

// file: design/iplr_pkg.sv
// constants for the interrupt priority level register block
package iplr_pkg;

  // ----------------------------------------------------------------------
  // register map (index; byte address is four times the index)
  // ----------------------------------------------------------------------
  localparam int REG_COUNT = 4;
  localparam int REG_IDX_DEBUG_A = 0;
  localparam int REG_IDX_DEBUG_B = 1;
  localparam int REG_IDX_SYSTEM = 2;
  localparam int REG_IDX_PORT_CAN = 3;
  localparam int REG_W = 16;

  localparam logic [15:0] RESET_DEBUG_A = 16'h0000;
  localparam logic [15:0] RESET_DEBUG_B = 16'h0000;
  localparam logic [15:0] RESET_SYSTEM = 16'h0000;
  localparam logic [15:0] RESET_PORT_CAN = 16'h0000;

  // implemented bits; everything else is reserved, reads zero
  localparam logic [15:0] WMASK_DEBUG_A = 16'h3c00;
  localparam logic [15:0] WMASK_DEBUG_B = 16'h003f;
  localparam logic [15:0] WMASK_SYSTEM = 16'hffcf;
  localparam logic [15:0] WMASK_PORT_CAN = 16'hfffc;

  // ----------------------------------------------------------------------
  // interrupt sources
  // ----------------------------------------------------------------------
  localparam int SRC_COUNT = 19;
  localparam int SRC_BREAKPOINT0 = 0;
  localparam int SRC_STEP_COUNTER = 1;
  localparam int SRC_DEBUG_RX_FULL = 2;
  localparam int SRC_DEBUG_TX_EMPTY = 3;
  localparam int SRC_TRACE_BUFFER = 4;
  localparam int SRC_FLASH_BUFFERS_EMPTY = 5;
  localparam int SRC_FLASH_CMD_COMPLETE = 6;
  localparam int SRC_FLASH_ERROR = 7;
  localparam int SRC_CLOCK_LOCK = 8;
  localparam int SRC_LOW_VOLTAGE = 9;
  localparam int SRC_EXT_PIN_B = 10;
  localparam int SRC_EXT_PIN_A = 11;
  localparam int SRC_PORT_D = 12;
  localparam int SRC_PORT_E = 13;
  localparam int SRC_PORT_F = 14;
  localparam int SRC_CAN_MSG_BUFFER = 15;
  localparam int SRC_CAN_WAKEUP = 16;
  localparam int SRC_CAN_ERROR = 17;
  localparam int SRC_CAN_BUS_OFF = 18;

  // word, field position and level range of each source, by source number
  localparam int SRC_WORD [SRC_COUNT] = '{
    0, 0, 1, 1, 1, 2, 2, 2, 2, 2, 2, 2, 3, 3, 3, 3, 3, 3, 3};
  localparam int SRC_LSB [SRC_COUNT] = '{
    12, 10, 4, 2, 0, 14, 12, 10, 8, 6, 2, 0, 14, 12, 10, 8, 6, 4, 2};
  localparam bit SRC_DEBUG [SRC_COUNT] = '{
    1, 1, 1, 1, 1, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0};

  // field code 01 maps to level 1 for debug sources, level 0 otherwise
  localparam logic [1:0] LEVEL_OFFSET_DEBUG = 2'h0;
  localparam logic [1:0] LEVEL_OFFSET_SYSTEM = 2'h3;
  localparam logic [1:0] FIELD_DISABLED = 2'h0;

  // ----------------------------------------------------------------------
  // bus answers
  // ----------------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

endpackage

// file: design/iplr_top.sv
// priority level registers with axi4-lite access and request tagging
`timescale 1ns/1ps
// Operation
// - debug sources: 00 off, 01 level 1, 10 level 2, 11 level 3
// - flash, clock-lock, low-voltage, pin sources: 00 off, levels 0 to 2
// - port and can sources use same 0 to 2 decoding, off at reset
// - reserved bits read zero and ignore writes
// - word 0: breakpoint 0 in bits 13-12, step counter in 11-10
// - word 1: receive full 5-4, transmit empty 3-2, trace 1-0
// - word 2: flash buffers empty 15-14, command 13-12, error 11-10
// - word 2: lock 9-8, low voltage 7-6, pin b 3-2, pin a 1-0
// - word 3: ports d,e,f 15-10, can buffer 9-8, can wake-up 7-6
module iplr_top import iplr_pkg::*; #(
  parameter int ADDR_W = 8
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // interrupt sources, same clock
  input wire logic [SRC_COUNT-1:0] src_irq,
  // requests to the core
  output logic [SRC_COUNT-1:0] req_valid,
  output logic [2*SRC_COUNT-1:0] req_level
);

  localparam int IDX_W = ADDR_W - 2;
  localparam logic [15:0] WMASK [REG_COUNT] = '{
    WMASK_DEBUG_A, WMASK_DEBUG_B, WMASK_SYSTEM, WMASK_PORT_CAN};
  localparam logic [15:0] RESETS [REG_COUNT] = '{
    RESET_DEBUG_A, RESET_DEBUG_B, RESET_SYSTEM, RESET_PORT_CAN};

  // ----------------------------------------------------------------------
  // write channel
  // ----------------------------------------------------------------------
  logic aw_held_reg, aw_held_next;
  logic [IDX_W-1:0] aw_idx_reg, aw_idx_next;
  logic w_held_reg, w_held_next;
  logic [15:0] wdata_reg, wdata_next;
  logic [1:0] wstrb_reg, wstrb_next;
  logic bvalid_reg, bvalid_next;
  logic [1:0] bresp_reg, bresp_next;
  logic [15:0] pri_reg [REG_COUNT];
  logic [15:0] pri_next [REG_COUNT];
  logic do_write;
  logic [15:0] lane_mask;

  assign s_axi_awready = !aw_held_reg;
  assign s_axi_wready = !w_held_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;

  always_comb begin
    aw_held_next = aw_held_reg;
    aw_idx_next = aw_idx_reg;
    w_held_next = w_held_reg;
    wdata_next = wdata_reg;
    wstrb_next = wstrb_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    for (int i = 0; i < REG_COUNT; i++) begin
      pri_next[i] = pri_reg[i];
    end
    lane_mask = {{8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};
    // one write in flight: the next waits until the response is taken
    do_write = aw_held_reg && w_held_reg && !bvalid_reg;
    if (bvalid_reg && s_axi_bready) begin
      bvalid_next = 1'b0;
    end
    if (s_axi_awvalid && !aw_held_reg) begin
      aw_held_next = 1'b1;
      aw_idx_next = s_axi_awaddr[ADDR_W-1:2];
    end
    if (s_axi_wvalid && !w_held_reg) begin
      w_held_next = 1'b1;
      wdata_next = s_axi_wdata[15:0];
      wstrb_next = s_axi_wstrb[1:0];
    end
    if (do_write) begin
      aw_held_next = 1'b0;
      w_held_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = RESP_DECERR;
      for (int i = 0; i < REG_COUNT; i++) begin
        if (aw_idx_reg == IDX_W'(i)) begin
          bresp_next = RESP_OKAY;
          // reserved bits never take a value
          pri_next[i] = ((pri_reg[i] & ~lane_mask) |
                         (wdata_reg & lane_mask)) & WMASK[i];
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      aw_idx_reg <= '0;
      w_held_reg <= 1'b0;
      wdata_reg <= '0;
      wstrb_reg <= '0;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
      for (int i = 0; i < REG_COUNT; i++) begin
        pri_reg[i] <= RESETS[i];
      end
    end else begin
      aw_held_reg <= aw_held_next;
      aw_idx_reg <= aw_idx_next;
      w_held_reg <= w_held_next;
      wdata_reg <= wdata_next;
      wstrb_reg <= wstrb_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      for (int i = 0; i < REG_COUNT; i++) begin
        pri_reg[i] <= pri_next[i];
      end
    end
  end

  // ----------------------------------------------------------------------
  // read channel
  // ----------------------------------------------------------------------
  logic rvalid_reg, rvalid_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [1:0] rresp_reg, rresp_next;
  logic [IDX_W-1:0] rd_idx_reg, rd_idx_next;
  logic [IDX_W-1:0] ar_idx;

  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign ar_idx = s_axi_araddr[ADDR_W-1:2];

  always_comb begin
    rvalid_next = rvalid_reg;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    rd_idx_next = rd_idx_reg;
    if (rvalid_reg && s_axi_rready) begin
      rvalid_next = 1'b0;
    end
    if (s_axi_arvalid && !rvalid_reg) begin
      rvalid_next = 1'b1;
      rd_idx_next = ar_idx;
      rdata_next = '0;
      rresp_next = RESP_DECERR;
      for (int i = 0; i < REG_COUNT; i++) begin
        if (ar_idx == IDX_W'(i)) begin
          rresp_next = RESP_OKAY;
          // upper half and reserved bits read zero
          rdata_next = {16'h0000, pri_reg[i] & WMASK[i]};
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= '0;
      rresp_reg <= RESP_OKAY;
      rd_idx_reg <= '0;
    end else begin
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
      rd_idx_reg <= rd_idx_next;
    end
  end

  // ----------------------------------------------------------------------
  // request forwarding
  // ----------------------------------------------------------------------
  logic [SRC_COUNT-1:0] src_en;
  logic [2*SRC_COUNT-1:0] src_lvl;
  logic [SRC_COUNT-1:0] req_valid_reg, req_valid_next;
  logic [2*SRC_COUNT-1:0] req_level_reg, req_level_next;

  for (genvar g = 0; g < SRC_COUNT; g++) begin : g_src
    iplr_level_decode #(
      .LEVEL_OFFSET(SRC_DEBUG[g] ? LEVEL_OFFSET_DEBUG : LEVEL_OFFSET_SYSTEM)
    ) u_dec (
      .field(pri_reg[SRC_WORD[g]][SRC_LSB[g] +: 2]),
      .enabled(src_en[g]),
      .level(src_lvl[2*g +: 2])
    );
  end

  always_comb begin
    req_valid_next = src_irq & src_en;
    // level is zero while no request is shown
    for (int i = 0; i < SRC_COUNT; i++) begin
      req_level_next[2*i +: 2] = req_valid_next[i] ?
                                 src_lvl[2*i +: 2] : 2'h0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      req_valid_reg <= '0;
      req_level_reg <= '0;
    end else begin
      req_valid_reg <= req_valid_next;
      req_level_reg <= req_level_next;
    end
  end

  assign req_valid = req_valid_reg;
  assign req_level = req_level_reg;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  AST_DEBUG_LEVEL: assert property
    (@(posedge aclk) disable iff (!aresetn)
    (src_irq[SRC_BREAKPOINT0] && pri_reg[0][13:12] != 2'h0) |=>
    (req_valid[SRC_BREAKPOINT0] &&
     req_level[2*SRC_BREAKPOINT0 +: 2] == $past(pri_reg[0][13:12])))
    else $error("breakpoint level not equal to field code");

  AST_SYSTEM_LEVEL: assert property
    (@(posedge aclk) disable iff (!aresetn)
    (src_irq[SRC_FLASH_BUFFERS_EMPTY] && pri_reg[2][15:14] != 2'h0) |=>
    (req_level[2*SRC_FLASH_BUFFERS_EMPTY +: 2] ==
     2'($past(pri_reg[2][15:14]) - 2'h1)))
    else $error("flash buffers level not field code minus one");

  AST_PORT_LEVEL: assert property
    (@(posedge aclk) disable iff (!aresetn)
    (src_irq[SRC_PORT_D] && pri_reg[3][15:14] == 2'h3) |=>
    (req_valid[SRC_PORT_D] && req_level[2*SRC_PORT_D +: 2] == 2'h2))
    else $error("port d code 11 not level 2");

  AST_RESET_OFF: assert property
    (@(posedge aclk)
    !aresetn |=> (pri_reg[2] == 16'h0000 && pri_reg[3] == 16'h0000 &&
                  req_valid == '0))
    else $error("priority fields not disabled after reset");

  AST_RESERVED_ZERO: assert property
    (@(posedge aclk) disable iff (!aresetn)
    (s_axi_rvalid && rd_idx_reg == IDX_W'(0)) |->
    (s_axi_rdata[31:14] == '0 && s_axi_rdata[9:0] == '0))
    else $error("reserved bits of word 0 read nonzero");

  AST_RESERVED_W2: assert property
    (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid && rd_idx_reg == IDX_W'(2) |-> s_axi_rdata[5:4] == 2'h0)
    else $error("reserved bits of word 2 read nonzero");

  AST_TRACE_FIELD: assert property
    (@(posedge aclk) disable iff (!aresetn)
    (src_irq[SRC_TRACE_BUFFER] && pri_reg[1][1:0] == 2'h1) |=>
    req_valid[SRC_TRACE_BUFFER] && req_level[2*SRC_TRACE_BUFFER +: 2] == 2'h1)
    else $error("trace buffer field not in bits 1-0");

  AST_PIN_A_FIELD: assert property
    (@(posedge aclk) disable iff (!aresetn)
    (src_irq[SRC_EXT_PIN_A] && pri_reg[2][1:0] == 2'h2) |=>
    req_valid[SRC_EXT_PIN_A] && req_level[2*SRC_EXT_PIN_A +: 2] == 2'h1)
    else $error("pin a code 10 not level 1");

  AST_WAKE_FIELD: assert property
    (@(posedge aclk) disable iff (!aresetn)
    (src_irq[SRC_CAN_WAKEUP] && pri_reg[3][7:6] == 2'h1) |=>
    req_valid[SRC_CAN_WAKEUP] && req_level[2*SRC_CAN_WAKEUP +: 2] == 2'h0)
    else $error("can wake-up code 01 not level 0");

  AST_OFF_NO_REQ: assert property
    (@(posedge aclk) disable iff (!aresetn)
    (pri_reg[0][11:10] == 2'h0 || !src_irq[SRC_STEP_COUNTER]) |=>
    !req_valid[SRC_STEP_COUNTER] &&
    req_level[2*SRC_STEP_COUNTER +: 2] == 2'h0)
    else $error("disabled step counter raised a request");

  AST_WRITE_RESP: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before taken");

  AST_READ_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_rvalid && !s_axi_rready) |=>
    (s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp)))
    else $error("read answer changed before taken");

  AST_UPPER_ZERO: assert property
    (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
    else $error("upper half of read data nonzero");

  AST_RESERVED_W1: assert property
    (@(posedge aclk) disable iff (!aresetn)
    (s_axi_rvalid && rd_idx_reg == IDX_W'(1)) |-> s_axi_rdata[15:6] == '0)
    else $error("reserved bits of word 1 read nonzero");

  AST_RESERVED_HELD: assert property
    (@(posedge aclk) disable iff (!aresetn)
    (pri_reg[0] & ~WMASK_DEBUG_A) == 16'h0000 &&
    (pri_reg[1] & ~WMASK_DEBUG_B) == 16'h0000 &&
    (pri_reg[2] & ~WMASK_SYSTEM) == 16'h0000 &&
    (pri_reg[3] & ~WMASK_PORT_CAN) == 16'h0000)
    else $error("reserved storage bit set");

  AST_DEBUG_NOT_ZERO: assert property
    (@(posedge aclk) disable iff (!aresetn)
    !(req_valid[SRC_STEP_COUNTER] &&
      req_level[2*SRC_STEP_COUNTER +: 2] == 2'h0) &&
    !(req_valid[SRC_DEBUG_TX_EMPTY] &&
      req_level[2*SRC_DEBUG_TX_EMPTY +: 2] == 2'h0))
    else $error("debug source shown at level 0");

  AST_SYSTEM_NOT_THREE: assert property
    (@(posedge aclk) disable iff (!aresetn)
    req_level[2*SRC_FLASH_ERROR +: 2] != 2'h3 &&
    req_level[2*SRC_LOW_VOLTAGE +: 2] != 2'h3 &&
    req_level[2*SRC_CAN_MSG_BUFFER +: 2] != 2'h3)
    else $error("system source shown at level 3");

  AST_RX_FIELD: assert property
    (@(posedge aclk) disable iff (!aresetn)
    (src_irq[SRC_DEBUG_RX_FULL] && pri_reg[1][5:4] == 2'h3) |=>
    req_valid[SRC_DEBUG_RX_FULL] &&
    req_level[2*SRC_DEBUG_RX_FULL +: 2] == 2'h3)
    else $error("debug receive full code 11 not level 3");

  AST_LOCK_FIELD: assert property
    (@(posedge aclk) disable iff (!aresetn)
    (src_irq[SRC_CLOCK_LOCK] && pri_reg[2][9:8] == 2'h3) |=>
    req_valid[SRC_CLOCK_LOCK] && req_level[2*SRC_CLOCK_LOCK +: 2] == 2'h2)
    else $error("clock lock code 11 not level 2");

  AST_PORT_F_FIELD: assert property
    (@(posedge aclk) disable iff (!aresetn)
    (src_irq[SRC_PORT_F] && pri_reg[3][11:10] == 2'h2) |=>
    req_valid[SRC_PORT_F] && req_level[2*SRC_PORT_F +: 2] == 2'h1)
    else $error("port f code 10 not level 1");

endmodule
